// ---- hdl/ioa_pkg.sv ----
package ioa_pkg;
    // ==========================================================
    // widths
    localparam int PA_W   = 6;
    localparam int PB_W   = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CFG_W  = 3;
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFF_PA_DATA = 8'h05;
    localparam logic [7:0] OFF_PB_DATA = 8'h06;
    localparam logic [7:0] OFF_PA_DIR  = 8'h85;
    localparam logic [7:0] OFF_PB_DIR  = 8'h86;
    localparam logic [7:0] OFF_ACFG    = 8'h9F;
    localparam logic [7:0] OFF_PERI_EN = 8'hA0;
    // ==========================================================
    // reset values and field positions
    localparam logic [5:0] RST_PA_DIR  = 6'h3F;
    localparam logic [7:0] RST_PB_DIR  = 8'hFF;
    localparam logic [2:0] RST_ACFG    = 3'h0;
    localparam logic [5:0] RST_PA_LAT  = 6'h00;
    localparam logic [7:0] RST_PB_LAT  = 8'h00;
    localparam int         BIT_TMR     = 4;
    localparam int         BIT_SS      = 5;
    localparam int         PEN_TMR     = 0;
    localparam int         PEN_SS      = 1;
    // analog config code selecting all pins digital
    localparam logic [2:0] ACFG_ALL_DIG = 3'h7;
    // code where pin 3 is the reference input
    localparam logic [2:0] ACFG_VREF    = 3'h5;
endpackage

// ---- hdl/ioa_sync.sv ----
`timescale 1ns/10ps
// two-stage synchroniser for a bus of pins
module ioa_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys, // core clock
    input  wire logic         rstn,    // sync reset, active low
    input  wire logic         ce,      // clock enable
    input  wire logic [W-1:0] d,       // async pins
    output logic      [W-1:0] q        // synchronised level
);
    logic [W-1:0] s1_r;     // first stage, read only by second
    logic [W-1:0] s2_r;     // second stage
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_nxt;

    // ==========================================================
    // next values
    always_comb begin
        s1_nxt = s1_r;
        s2_nxt = s2_r;
        if (ce) begin
            s1_nxt = d;
            s2_nxt = s1_r;
        end
    end

    // registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign q = s2_r;
endmodule

// ---- hdl/ioa_port.sv ----
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module ioa_port
    import ioa_pkg::*;
(
    input  wire logic                      clk_sys,     // core clock 200 MHz
    input  wire logic                      rstn,        // sync reset, active low
    input  wire logic                      ce,          // clock enable
    input  wire logic                      por_evt,     // reset is power-on/brown-out
    input  wire logic [ioa_pkg::ADDR_W-1:0] addr,       // register address
    input  wire logic [ioa_pkg::DATA_W-1:0] wdata,      // write data
    input  wire logic                      wr,          // write strobe
    input  wire logic                      rd,          // read strobe
    output logic      [ioa_pkg::DATA_W-1:0] rdata,      // read data, cycle after rd
    input  wire logic [ioa_pkg::PA_W-1:0]   pa_in,      // port a pin levels
    output logic      [ioa_pkg::PA_W-1:0]   pa_out,     // port a pin drive value
    output logic      [ioa_pkg::PA_W-1:0]   pa_oe,      // port a drive enable
    input  wire logic [ioa_pkg::PB_W-1:0]   pb_in,      // port b pin levels
    output logic      [ioa_pkg::PB_W-1:0]   pb_out,     // port b pin drive value
    output logic      [ioa_pkg::PB_W-1:0]   pb_oe,      // port b drive enable
    input  wire logic                      ss_per_out,  // serial port drive for pin five
    input  wire logic                      ss_per_oe,   // serial port enable on pin five
    output logic                           timer_ext_clock_in, // timer clock, synced
    output logic                           slave_select_in,    // serial slave select
    output logic      [ioa_pkg::PA_W-1:0]   analog_sel  // pins in analog mode
);
    import ioa_pkg::*;

    // ==========================================================
    // analog decode
    // per pin: 1 = analog input (pin reads zero digitally)
    function automatic logic [PA_W-1:0] ana_mask(input logic [CFG_W-1:0] c);
        logic [PA_W-1:0] m;
        m = 6'h2F;                       // pins 0..3 and 5 analog
        case (c)
            3'h0, 3'h1: m = 6'h2F;       // pins 0..3 and 5 analog
            3'h2, 3'h3: m = 6'h0F;       // pins 0..3 analog
            3'h4, 3'h5: m = 6'h0B;       // pins 0,1,3 analog
            3'h6, 3'h7: m = 6'h00;       // all digital
            default:    m = 6'h2F;
        endcase
        return m;
    endfunction

    // ==========================================================
    // state
    logic [PA_W-1:0]  pa_lat_r, pa_lat_nxt;   // port a latch
    logic [PA_W-1:0]  pa_dir_r, pa_dir_nxt;   // port a direction
    logic [PB_W-1:0]  pb_lat_r, pb_lat_nxt;   // port b latch
    logic [PB_W-1:0]  pb_dir_r, pb_dir_nxt;   // port b direction
    logic [CFG_W-1:0] acfg_r,   acfg_nxt;     // analog config
    logic [1:0]       pen_r,    pen_nxt;      // peripheral enables
    logic [DATA_W-1:0] rdata_r, rdata_nxt;    // read data
    logic [PA_W-1:0]  pa_sync;                // synced pins a
    logic [PB_W-1:0]  pb_sync;                // synced pins b
    logic [PA_W-1:0]  pa_dig;                 // digital read value a
    logic [PA_W-1:0]  amask;                  // analog pins

    // ==========================================================
    // pin synchronisers
    ioa_sync #(.W(PA_W)) u_sync_a (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .d       (pa_in),
        .q       (pa_sync)
    );
    ioa_sync #(.W(PB_W)) u_sync_b (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .d       (pb_in),
        .q       (pb_sync)
    );

    assign amask  = ana_mask(acfg_r);
    // analog pins read zero digitally
    assign pa_dig = pa_sync & ~amask;

    // ==========================================================
    // register next values
    always_comb begin
        pa_lat_nxt = pa_lat_r;
        pa_dir_nxt = pa_dir_r;
        pb_lat_nxt = pb_lat_r;
        pb_dir_nxt = pb_dir_r;
        acfg_nxt   = acfg_r;
        pen_nxt    = pen_r;
        rdata_nxt  = '0;
        if (wr) begin
            case (addr)
                // read-modify-write: full byte from the cpu replaces whole latch
                OFF_PA_DATA: pa_lat_nxt = wdata[PA_W-1:0];
                OFF_PA_DIR:  pa_dir_nxt = wdata[PA_W-1:0];
                OFF_PB_DATA: pb_lat_nxt = wdata;
                OFF_PB_DIR:  pb_dir_nxt = wdata;
                OFF_ACFG:    acfg_nxt   = wdata[CFG_W-1:0];
                OFF_PERI_EN: pen_nxt    = wdata[1:0];
                default: ;                                     // unmapped ignored
            endcase
        end
        if (rd) begin
            case (addr)
                OFF_PA_DATA: rdata_nxt = {2'h0, pa_dig};
                OFF_PA_DIR:  rdata_nxt = {2'h0, pa_dir_r};
                OFF_PB_DATA: rdata_nxt = pb_sync;
                OFF_PB_DIR:  rdata_nxt = pb_dir_r;
                OFF_ACFG:    rdata_nxt = {5'h00, acfg_r};
                OFF_PERI_EN: rdata_nxt = {6'h00, pen_r};
                default:     rdata_nxt = '0;                  // unmapped reads zero
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pa_dir_r <= RST_PA_DIR;
            pb_dir_r <= RST_PB_DIR;
            acfg_r   <= RST_ACFG;
            pen_r    <= 2'h0;
            rdata_r  <= '0;
            pa_lat_r[BIT_TMR] <= 1'b0;
        end else if (ce) begin
            pa_lat_r <= pa_lat_nxt;
            pa_dir_r <= pa_dir_nxt;
            pb_lat_r <= pb_lat_nxt;
            pb_dir_r <= pb_dir_nxt;
            acfg_r   <= acfg_nxt;
            pen_r    <= pen_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // ==========================================================
    // pin drivers
    always_comb begin
        for (int i = 0; i < PA_W; i++) begin
            pa_oe[i]  = ~pa_dir_r[i];
            pa_out[i] = pa_lat_r[i];
        end
        // open drain: only pull low, float when latch is one
        pa_out[BIT_TMR] = 1'b0;
        pa_oe[BIT_TMR]  = ~pa_dir_r[BIT_TMR] & ~pa_lat_r[BIT_TMR];
        // serial port owns pin five while enabled
        if (pen_r[PEN_SS]) begin
            pa_out[BIT_SS] = ss_per_out;
            pa_oe[BIT_SS]  = ss_per_oe;
        end
        pb_oe  = ~pb_dir_r;
        pb_out = pb_lat_r;
    end

    assign rdata              = rdata_r;
    assign analog_sel         = amask;
    assign timer_ext_clock_in = pa_sync[BIT_TMR] & pen_r[PEN_TMR];
    assign slave_select_in    = pa_sync[BIT_SS] | ~pen_r[PEN_SS];

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    dir_reset_a: assert property ($rose(rstn) |-> pa_dir_r == 6'h3F)
        else $error("direction not all input after reset");
    hiz_input_a: assert property (pa_dir_r[0] |-> !pa_oe[0])
        else $error("input pin driven");
    drive_lat_a: assert property (!pa_dir_r[1] |-> pa_oe[1] && pa_out[1] == pa_lat_r[1])
        else $error("output pin not driving latch");
    od_pin4_a: assert property (pa_oe[BIT_TMR] |-> pa_out[BIT_TMR] == 1'b0)
        else $error("pin four drove high");
    write_lat_a: assert property (ce && wr && addr == OFF_PA_DATA
                                  |=> pa_lat_r == $past(wdata[5:0]))
        else $error("latch not updated by write");
    upper_zero_a: assert property (ce && rd && addr == OFF_PA_DIR |=> rdata_r[7:6] == 2'h0)
        else $error("upper bits not zero");
    analog_zero_a: assert property (ce && rd && addr == OFF_PA_DATA && acfg_r == 3'h0
                                    |=> rdata[5:0] == {1'b0, $past(pa_sync[4]), 4'h0})
        else $error("analog pin read nonzero");
    sync_delay_a: assert property (ce && $past(ce) && $past(rstn)
                                   |=> pa_sync == $past(pa_in, 2))
        else $error("synchroniser delay wrong");
    b_dir_a: assert property (pb_dir_r[7] |-> !pb_oe[7])
        else $error("port b input driven");
    per_own_a: assert property (pen_r[PEN_SS] |-> pa_oe[BIT_SS] == ss_per_oe)
        else $error("peripheral does not own pin five");

    wr_pa_c:  cover property (wr && addr == OFF_PA_DATA);
    rd_pa_c:  cover property (rd && addr == OFF_PA_DATA ##1 rdata != 8'h00);
    ana_c:    cover property (acfg_r == ACFG_ALL_DIG);
    od_low_c: cover property (pa_oe[BIT_TMR]);
endmodule

// ---- tb/ioa_pin_model.sv ----
`timescale 1ns/10ps
// ==========================================
// pad model: resolves pin levels from all drivers
module ioa_pin_model
    import ioa_pkg::*;
(
    input  wire logic [ioa_pkg::PA_W-1:0] pa_out, // port a drive value
    input  wire logic [ioa_pkg::PA_W-1:0] pa_oe,  // port a drive enable
    input  wire logic [ioa_pkg::PA_W-1:0] ext_a,  // outside level, port a
    input  wire logic [ioa_pkg::PB_W-1:0] pb_out, // port b drive value
    input  wire logic [ioa_pkg::PB_W-1:0] pb_oe,  // port b drive enable
    input  wire logic [ioa_pkg::PB_W-1:0] ext_b,  // outside level, port b
    output logic      [ioa_pkg::PA_W-1:0] pa_in,  // port a pad level
    output logic      [ioa_pkg::PB_W-1:0] pb_in   // port b pad level
);
    // driven pins follow the device, released pins the outside world
    always_comb begin
        for (int i = 0; i < PA_W; i++) begin
            pa_in[i] = pa_oe[i] ? pa_out[i] : ext_a[i];
        end
        // open drain: the device can only pull this pad low
        pa_in[BIT_TMR] = pa_oe[BIT_TMR] ? 1'b0 : ext_a[BIT_TMR];
        pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
    end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    import ioa_pkg::*;
    logic       clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, por_evt = 1'b0;
    logic       wr = 1'b0, rd = 1'b0, ss_per_out = 1'b0, ss_per_oe = 1'b0, tclk, ssel;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pb_in, pb_out, pb_oe, ext_b = 8'h00;
    logic [5:0] pa_in, pa_out, pa_oe, asel, ext_a = 6'h3F;
    int         bad_count = 0, check_count = 0;
    always #2.5 clk_sys = ~clk_sys;
    ioa_port dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .por_evt(por_evt), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out),
        .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .ss_per_out(ss_per_out),
        .ss_per_oe(ss_per_oe), .timer_ext_clock_in(tclk), .slave_select_in(ssel),
        .analog_sel(asel));
    ioa_pin_model pins (.pa_out(pa_out), .pa_oe(pa_oe), .ext_a(ext_a), .pb_out(pb_out),
        .pb_oe(pb_oe), .ext_b(ext_b), .pa_in(pa_in), .pb_in(pb_in));
    // ==========================================
    // bus and compare helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk({2'h0, pa_oe}, 8'h00);
        chk(pb_oe, 8'h00);
        chk({2'h0, asel}, 8'h2F);
        rd_chk(OFF_PA_DIR, 8'h3F);
        rd_chk(OFF_ACFG, 8'h00);
        rd_chk(OFF_PA_DATA, 8'h10);
        $display("reset test done");
    endtask
    task automatic t_drive();
        wr_reg(OFF_ACFG, {5'h00, ACFG_ALL_DIG});
        wr_reg(OFF_PA_DATA, 8'hFF);
        wr_reg(OFF_PA_DIR, 8'h00);
        chk({2'h0, pa_oe}, 8'h2F);
        chk({2'h0, pa_out & 6'h2F}, 8'h2F);
        @(posedge clk_sys) ext_a <= 6'h00;
        wr_reg(OFF_PA_DATA, 8'h2A);
        chk({2'h0, pa_oe}, 8'h3F);
        repeat (3) @(posedge clk_sys);
        rd_chk(OFF_PA_DATA, 8'h2A);
        rd_chk(OFF_PA_DIR, 8'h00);
        rd_chk(8'h40, 8'h00);
        $display("drive test done");
    endtask
    task automatic t_analog();
        logic [5:0] exp_sel [8] = '{6'h2F, 6'h2F, 6'h0F, 6'h0F, 6'h0B, 6'h0B, 6'h00, 6'h00};
        for (int c = 0; c < 8; c++) begin
            wr_reg(OFF_ACFG, 8'(c));
            chk({2'h0, asel}, {2'h0, exp_sel[c]});
            chk({2'h0, pa_oe}, 8'h3F);
        end
        wr_reg(OFF_PA_DIR, 8'h3F);
        $display("analog test done");
    endtask
    task automatic t_periph();
        @(posedge clk_sys) ext_a <= 6'h10;
        wr_reg(OFF_PERI_EN, 8'h01);
        repeat (3) @(posedge clk_sys);
        #1 chk({6'h00, tclk, ssel}, 8'h03);
        wr_reg(OFF_PERI_EN, 8'h02);
        repeat (3) @(posedge clk_sys);
        #1 chk({6'h00, tclk, ssel}, 8'h00);
        @(posedge clk_sys) ss_per_oe <= 1'b1;
        @(posedge clk_sys) ss_per_out <= 1'b1;
        #1 chk({6'h00, pa_oe[BIT_SS], pa_out[BIT_SS]}, 8'h03);
        wr_reg(OFF_PERI_EN, 8'h00);
        $display("peripheral test done");
    endtask
    task automatic t_port_b_data();
        @(posedge clk_sys) ext_b <= 8'h3C;
        wr_reg(OFF_PB_DATA, 8'hA5);
        wr_reg(OFF_PB_DIR, 8'h0F);
        chk(pb_oe, 8'hF0);
        chk(pb_out & 8'hF0, 8'hA0);
        repeat (3) @(posedge clk_sys);
        rd_chk(OFF_PB_DATA, 8'hAC);
        rd_chk(OFF_PB_DIR, 8'h0F);
        $display("port b test done");
    endtask
    // mid-run reset keeps the latch except its open-drain bit
    task automatic t_rst2();
        wr_reg(OFF_PA_DATA, 8'h3F);
        @(posedge clk_sys) rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rd_chk(OFF_PA_DIR, 8'h3F);
        wr_reg(OFF_ACFG, 8'h07);
        wr_reg(OFF_PA_DIR, 8'h00);
        chk({2'h0, pa_oe}, 8'h3F);
        chk({2'h0, pa_out & 6'h2F}, 8'h2F);
        // clock enable low: a write must leave the direction untouched
        @(posedge clk_sys) ce <= 1'b0;
        wr_reg(OFF_PA_DIR, 8'h3F);
        @(posedge clk_sys) ce <= 1'b1;
        #1 chk({2'h0, pa_oe}, 8'h3F);
        $display("second reset test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==========================================
    // main sequence and hang guard
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_drive();
        t_analog();
        t_periph();
        t_port_b_data();
        t_rst2();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        results();
    end
endmodule
